// File: sanitize_pkg.sv
// Purpose: Shared constants, types and the acceptance check of the sanitize command handler.
// Assumes: Command words 10 and 11 arrive already fetched from the admin queue.
// Notes:   The check module is purely combinational; the top registers its results.
package sanitize_pkg;
   // Command word 10 field layout
   localparam int ACT_LSB       = 0;
   localparam int ACT_W         = 3;
   localparam int UNRES_BIT     = 3;
   localparam int OWPASS_LSB    = 4;
   localparam int OWPASS_W      = 4;
   localparam int OIPBP_BIT     = 8;
   localparam int NODEALLOC_BIT = 9;
   // Action codes
   localparam logic [2:0] ACT_EXIT_FAILURE = 3'h1;
   localparam logic [2:0] ACT_BLOCK_ERASE  = 3'h2;
   localparam logic [2:0] ACT_OVERWRITE    = 3'h3;
   localparam logic [2:0] ACT_CRYPTO_ERASE = 3'h4;
   // Bits of the supported-type mask
   localparam int SUP_BLOCK     = 0;
   localparam int SUP_CRYPTO    = 1;
   localparam int SUP_OVERWRITE = 2;
   localparam int SUP_W         = 3;
   localparam logic [2:0] SUP_ALL = 3'h7;

   typedef enum logic [1:0] {SAN_IDLE, SAN_BUSY, SAN_FAILED} san_state_type;

   typedef enum logic [3:0] {
      ST_SUCCESS, ST_INVALID_FIELD, ST_IN_PROGRESS, ST_FAILED, ST_PMR_PROHIBITED,
      ST_CMB_UNSUPPORTED, ST_FW_CTRL_RESET, ST_FW_CONV_RESET, ST_FW_SUBSYS_RESET
   } status_kind_type;

   typedef enum logic [1:0] {
      FWC_OTHER, FWC_CTRL_RESET, FWC_CONV_RESET, FWC_SUBSYS_RESET
   } fw_commit_type;

   typedef struct packed {
      logic        valid;
      logic        is_sanitize;
      logic        allowed;
      logic [31:0] cdw10;
      logic [31:0] cdw11;
   } cmd_type;

   typedef struct packed {
      logic            valid;
      logic            forward;
      status_kind_type status;
   } cpl_type;

   typedef struct packed {
      logic [2:0]  action;
      logic        unrestricted;
      logic        no_dealloc;
      logic        invert;
      logic [3:0]  passes;
      logic [31:0] pattern;
   } launch_type;

   typedef struct packed {
      logic [2:0] types;
      logic       nodealloc_modifies;
      logic       nodealloc_inhibited;
   } caps_type;
endpackage

`timescale 1ns/1ps

module sanitize_check (
   // Command under test
   input  wire sanitize_pkg::cmd_type         cmd,
   // Present state
   input  wire sanitize_pkg::san_state_type   state,
   input  wire logic                          last_unrestricted,
   input  wire logic [2:0]                    supported,
   // Conflicts
   input  wire logic                          pmr_enabled,
   input  wire logic                          cmb_block,
   input  wire logic                          fw_pending,
   input  wire sanitize_pkg::fw_commit_type   fw_status,
   // Verdict
   output sanitize_pkg::status_kind_type      status,
   output logic                               forward,
   output logic                               launch,
   output logic                               leave_failure
);
   logic [2:0] act;
   logic       unres;
   logic       type_ok;

   assign act   = cmd.cdw10[sanitize_pkg::ACT_LSB +: sanitize_pkg::ACT_W];
   assign unres = cmd.cdw10[sanitize_pkg::UNRES_BIT];

   always_comb begin
      case (act)
         sanitize_pkg::ACT_EXIT_FAILURE: type_ok = 1'b1;
         sanitize_pkg::ACT_BLOCK_ERASE:  type_ok = supported[sanitize_pkg::SUP_BLOCK];
         sanitize_pkg::ACT_OVERWRITE:    type_ok = supported[sanitize_pkg::SUP_OVERWRITE];
         sanitize_pkg::ACT_CRYPTO_ERASE: type_ok = supported[sanitize_pkg::SUP_CRYPTO];
         default:                        type_ok = 1'b0;
      endcase
   end

   always_comb begin
      status        = sanitize_pkg::ST_SUCCESS;
      forward       = 1'b0;
      launch        = 1'b0;
      leave_failure = 1'b0;
      if (!cmd.is_sanitize) begin
         if (cmd.allowed) begin
            forward = 1'b1;
         end else if (state == sanitize_pkg::SAN_BUSY) begin
            status = sanitize_pkg::ST_IN_PROGRESS;
         end else if (state == sanitize_pkg::SAN_FAILED) begin
            status = sanitize_pkg::ST_FAILED;
         end else begin
            forward = 1'b1;
         end
      end else if (pmr_enabled) begin
         status = sanitize_pkg::ST_PMR_PROHIBITED;
      end else if (cmb_block) begin
         status = sanitize_pkg::ST_CMB_UNSUPPORTED;
      end else if (fw_pending) begin
         // Reuse the reset kind that the firmware commit asked for; FWC_OTHER falls back to controller reset
         if (fw_status == sanitize_pkg::FWC_CONV_RESET) begin
            status = sanitize_pkg::ST_FW_CONV_RESET;
         end else if (fw_status == sanitize_pkg::FWC_SUBSYS_RESET) begin
            status = sanitize_pkg::ST_FW_SUBSYS_RESET;
         end else begin
            status = sanitize_pkg::ST_FW_CTRL_RESET;
         end
      end else if (state == sanitize_pkg::SAN_BUSY) begin
         status = sanitize_pkg::ST_IN_PROGRESS;
      end else if (!type_ok) begin
         status = sanitize_pkg::ST_INVALID_FIELD;
      end else if (act == sanitize_pkg::ACT_EXIT_FAILURE) begin
         if (state == sanitize_pkg::SAN_FAILED && !last_unrestricted) begin
            status = sanitize_pkg::ST_FAILED;
         end else begin
            leave_failure = (state == sanitize_pkg::SAN_FAILED);
         end
      end else if (state == sanitize_pkg::SAN_FAILED && !last_unrestricted && unres) begin
         status = sanitize_pkg::ST_FAILED;
      end else begin
         launch = 1'b1;
      end
   end
endmodule // sanitize_check

// File: sanitize_handler.sv
// Purpose: Accepts or aborts sanitize commands, launches the background erase and
//          tracks the subsystem sanitize state.
// Assumes: One command offered per cycle; the erase engine reports done or fail.
// Notes:   Every command is answered exactly one cycle after it is offered.
`timescale 1ns/1ps

module sanitize_handler #(
   parameter logic [2:0] SUPPORTED_TYPES     = sanitize_pkg::SUP_ALL,
   parameter logic       NODEALLOC_MODIFIES  = 1'b0,
   parameter logic       NODEALLOC_INHIBITED = 1'b0,
   parameter logic       CMB_SANITIZE_OK     = 1'b0
) (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   // Admin command offered for checking
   input  wire sanitize_pkg::cmd_type       cmd,
   // Subsystem conditions
   input  wire logic                        pmr_enabled,
   input  wire logic                        admin_queue_in_cmb,
   input  wire logic                        fw_reset_pending,
   input  wire sanitize_pkg::fw_commit_type fw_commit_status,
   // Erase engine report
   input  wire logic                        engine_done,
   input  wire logic                        engine_fail,
   // Completion
   output sanitize_pkg::cpl_type            cpl_q,
   // Erase engine launch
   output logic                             launch_q,
   output sanitize_pkg::launch_type         launch_info_q,
   // Side effects of a launch
   output logic                             clear_events_q,
   output logic                             log_update_q,
   output logic                             abort_selftest_q,
   output logic                             release_streams_q,
   // Levels while sanitizing
   output logic                             power_suspend_q,
   output logic                             fw_activate_block_q,
   // State and capability report
   output sanitize_pkg::san_state_type      state_q,
   output logic                             unrestricted_exit_allowed_q,
   output sanitize_pkg::caps_type           caps_q
);
   sanitize_pkg::san_state_type   state_d;
   logic                          unres_d;
   sanitize_pkg::cpl_type         cpl_d;
   logic                          launch_d;
   sanitize_pkg::launch_type      info_d;
   logic                          side_d;
   sanitize_pkg::caps_type        caps_d;

   sanitize_pkg::status_kind_type chk_status;
   logic                          chk_forward;
   logic                          chk_launch;
   logic                          chk_leave;
   logic                          cmb_block;
   logic [2:0]                    erase_action_code;

   assign cmb_block         = admin_queue_in_cmb && !CMB_SANITIZE_OK;
   assign erase_action_code = cmd.cdw10[sanitize_pkg::ACT_LSB +: sanitize_pkg::ACT_W];

   // Checks run against the registered state, so they see the outcome of earlier commands
   sanitize_check check_u (
      .cmd               (cmd),
      .state             (state_q),
      .last_unrestricted (unrestricted_exit_allowed_q),
      .supported         (SUPPORTED_TYPES),
      .pmr_enabled       (pmr_enabled),
      .cmb_block         (cmb_block),
      .fw_pending        (fw_reset_pending),
      .fw_status         (fw_commit_status),
      .status            (chk_status),
      .forward           (chk_forward),
      .launch            (chk_launch),
      .leave_failure     (chk_leave)
   );

   always_comb begin
      state_d  = state_q;
      unres_d  = unrestricted_exit_allowed_q;
      cpl_d    = '0;
      launch_d = 1'b0;
      info_d   = launch_info_q;
      side_d   = 1'b0;
      caps_d.types               = SUPPORTED_TYPES;
      caps_d.nodealloc_modifies  = NODEALLOC_MODIFIES;
      caps_d.nodealloc_inhibited = NODEALLOC_INHIBITED;

      // Engine reports only matter while an operation runs
      case (state_q)
         sanitize_pkg::SAN_BUSY: begin
            if (engine_fail) begin
               state_d = sanitize_pkg::SAN_FAILED;
            end else if (engine_done) begin
               state_d = sanitize_pkg::SAN_IDLE;
            end
         end
         default: begin
         end
      endcase

      if (cmd.valid) begin
         cpl_d.valid   = 1'b1;
         cpl_d.forward = chk_forward;
         cpl_d.status  = chk_status;
         if (chk_launch) begin
            // Completion says success while the engine is only just starting
            launch_d            = 1'b1;
            side_d              = 1'b1;
            state_d             = sanitize_pkg::SAN_BUSY;
            unres_d             = cmd.cdw10[sanitize_pkg::UNRES_BIT];
            info_d.action       = erase_action_code;
            info_d.unrestricted = cmd.cdw10[sanitize_pkg::UNRES_BIT];
            info_d.no_dealloc   = cmd.cdw10[sanitize_pkg::NODEALLOC_BIT] && !NODEALLOC_INHIBITED;
            info_d.invert       = cmd.cdw10[sanitize_pkg::OIPBP_BIT];
            info_d.passes       = cmd.cdw10[sanitize_pkg::OWPASS_LSB +: sanitize_pkg::OWPASS_W];
            info_d.pattern      = cmd.cdw11;
         end else if (chk_leave) begin
            state_d = sanitize_pkg::SAN_IDLE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q                     <= sanitize_pkg::SAN_IDLE;
         unrestricted_exit_allowed_q <= 1'b0;
         cpl_q                       <= '0;
         launch_q                    <= 1'b0;
         launch_info_q               <= '0;
         clear_events_q              <= 1'b0;
         log_update_q                <= 1'b0;
         abort_selftest_q            <= 1'b0;
         release_streams_q           <= 1'b0;
         power_suspend_q             <= 1'b0;
         fw_activate_block_q         <= 1'b0;
         caps_q                      <= '0;
      end else begin
         state_q                     <= state_d;
         unrestricted_exit_allowed_q <= unres_d;
         cpl_q                       <= cpl_d;
         launch_q                    <= launch_d;
         launch_info_q               <= info_d;
         clear_events_q              <= side_d;
         log_update_q                <= side_d;
         abort_selftest_q            <= side_d;
         release_streams_q           <= side_d;
         power_suspend_q             <= (state_d == sanitize_pkg::SAN_BUSY);
         fw_activate_block_q         <= (state_d == sanitize_pkg::SAN_BUSY);
         caps_q                      <= caps_d;
      end
   end

   // Checks on the registered answers
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic clean_now;
   assign clean_now = !pmr_enabled && !cmb_block && !fw_reset_pending;

   sequence sanitize_offered;
      cmd.valid && cmd.is_sanitize;
   endsequence

   sequence fw_blocked_offer;
      sanitize_offered and (!pmr_enabled && !cmb_block && fw_reset_pending);
   endsequence

   launch_success_a: assert property (launch_q |-> cpl_q.valid && !cpl_q.forward && cpl_q.status == sanitize_pkg::ST_SUCCESS)
      else $error("launch without success completion");

   launch_effects_a: assert property (launch_q |-> clear_events_q && log_update_q && abort_selftest_q && release_streams_q)
      else $error("launch missing a side effect");

   busy_suspend_a: assert property (launch_q |-> power_suspend_q && fw_activate_block_q && state_q == sanitize_pkg::SAN_BUSY)
      else $error("busy levels not raised on launch");

   reject_nothing_a: assert property (cpl_q.valid && cpl_q.status != sanitize_pkg::ST_SUCCESS |-> !launch_q && !log_update_q && $stable(launch_info_q))
      else $error("rejected command had an effect");

   pmr_reject_a: assert property (sanitize_offered and pmr_enabled |=> cpl_q.status == sanitize_pkg::ST_PMR_PROHIBITED)
      else $error("sanitize accepted with persistent region on");

   cmb_reject_a: assert property (sanitize_offered and (!pmr_enabled && cmb_block) |=> cpl_q.status == sanitize_pkg::ST_CMB_UNSUPPORTED)
      else $error("sanitize accepted with admin queue in buffer");

   fw_reject_a: assert property (fw_blocked_offer ##0 (fw_commit_status == sanitize_pkg::FWC_SUBSYS_RESET) |=> cpl_q.status == sanitize_pkg::ST_FW_SUBSYS_RESET)
      else $error("firmware reset kind not reused");

   fw_default_a: assert property (fw_blocked_offer ##0 (fw_commit_status == sanitize_pkg::FWC_OTHER) |=> cpl_q.status == sanitize_pkg::ST_FW_CTRL_RESET)
      else $error("firmware default status wrong");

   busy_reject_a: assert property (cmd.valid && !cmd.is_sanitize && !cmd.allowed && state_q == sanitize_pkg::SAN_BUSY |=> cpl_q.status == sanitize_pkg::ST_IN_PROGRESS && !cpl_q.forward)
      else $error("disallowed command passed while busy");

   failed_reject_a: assert property (cmd.valid && !cmd.is_sanitize && !cmd.allowed && state_q == sanitize_pkg::SAN_FAILED |=> cpl_q.status == sanitize_pkg::ST_FAILED)
      else $error("disallowed command passed after failure");

   restricted_exit_a: assert property (sanitize_offered and (clean_now && state_q == sanitize_pkg::SAN_FAILED && !unrestricted_exit_allowed_q && erase_action_code == sanitize_pkg::ACT_EXIT_FAILURE) |=> cpl_q.status == sanitize_pkg::ST_FAILED ##1 state_q == sanitize_pkg::SAN_FAILED)
      else $error("restricted failure left by exit action");

   restricted_unres_a: assert property (sanitize_offered and (clean_now && state_q == sanitize_pkg::SAN_FAILED && !unrestricted_exit_allowed_q && cmd.cdw10[sanitize_pkg::UNRES_BIT] && erase_action_code != sanitize_pkg::ACT_EXIT_FAILURE) |=> !launch_q)
      else $error("unrestricted retry after restricted failure");

   healthy_exit_a: assert property (sanitize_offered and (clean_now && state_q == sanitize_pkg::SAN_IDLE && erase_action_code == sanitize_pkg::ACT_EXIT_FAILURE) |=> cpl_q.status == sanitize_pkg::ST_SUCCESS && !launch_q && state_q == sanitize_pkg::SAN_IDLE)
      else $error("exit action did more than succeed");

   unsupported_a: assert property (sanitize_offered and (clean_now && state_q != sanitize_pkg::SAN_BUSY && erase_action_code == sanitize_pkg::ACT_CRYPTO_ERASE && !SUPPORTED_TYPES[sanitize_pkg::SUP_CRYPTO]) |=> cpl_q.status == sanitize_pkg::ST_INVALID_FIELD)
      else $error("unsupported type not rejected");
endmodule // sanitize_handler

// File: erase_engine_model.sv
// Purpose: Behavioural erase engine standing behind the sanitize handler's launch port.
// Assumes: The bench picks the delay and whether the next operation fails.
// Notes:   Reports come a programmed number of cycles after the launch, never with it.
`timescale 1ns/1ps

module erase_engine_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Launch and bench controls
   input  wire logic       launch,
   input  wire logic       fail_sel,
   input  wire logic [3:0] delay,
   // Report
   output logic            done,
   output logic            fail
);
   int cnt;
   initial begin
      done = 1'b0;
      fail = 1'b0;
      cnt  = -1;
   end
   // Work finishes at least one cycle after the command completion, never in the same cycle
   always @(posedge clk) begin
      #2;
      done = 1'b0;
      fail = 1'b0;
      if (!rst_b) begin
         cnt = -1;
      end else if (launch) begin
         cnt = int'(delay) + 1;
      end else if (cnt > 0) begin
         cnt = cnt - 1;
         if (cnt == 0) begin
            done = !fail_sel;
            fail = fail_sel;
            cnt  = -1;
         end
      end
   end
endmodule // erase_engine_model

// File: media_sanitize_command_handler_tb.sv
// Purpose: Self-checking bench comparing the sanitize handler with a behavioural model.
// Assumes: Supported types block erase and overwrite only; crypto erase is unsupported.
// Notes:   Model and design are compared at every clock edge after reset.
`timescale 1ns/1ps

module media_sanitize_command_handler_tb;
   logic                        clk = 1'b0;
   logic                        rst_b = 1'b0;
   sanitize_pkg::cmd_type       cmd = '0;
   logic                        pmr = 1'b0, controller_side_buffer = 1'b0, fwp = 1'b0, eng_fail_sel = 1'b0;
   sanitize_pkg::fw_commit_type fws = sanitize_pkg::FWC_OTHER;
   logic [3:0]                  eng_delay = 4'h3;
   logic                        eng_done, eng_fail, launch;
   sanitize_pkg::cpl_type       cpl;
   sanitize_pkg::launch_type    info;
   logic                        clr_ev, log_up, abort_st, rel_str, pwr_susp, fw_blk, unres;
   sanitize_pkg::san_state_type state;
   sanitize_pkg::caps_type      caps;
   sanitize_pkg::status_kind_type e_status;
   sanitize_pkg::san_state_type m_state;
   logic                        e_valid, e_launch, e_fwd, e_chkfwd, e_chkst, m_unres;
   logic [31:0]                 lfsr = 32'h30DE;
   int                          err_count = 0, tests_run = 0, cycles = 0;
   localparam logic [2:0]       TYPES = 3'h5;

   always #25 clk = ~clk;

   sanitize_handler #(.SUPPORTED_TYPES(TYPES), .NODEALLOC_MODIFIES(1'b1),
      .NODEALLOC_INHIBITED(1'b0), .CMB_SANITIZE_OK(1'b0)) i_sanitize_handler (
      .clk(clk), .rst_b(rst_b), .cmd(cmd), .pmr_enabled(pmr), .admin_queue_in_cmb(controller_side_buffer),
      .fw_reset_pending(fwp), .fw_commit_status(fws), .engine_done(eng_done),
      .engine_fail(eng_fail), .cpl_q(cpl), .launch_q(launch), .launch_info_q(info),
      .clear_events_q(clr_ev), .log_update_q(log_up), .abort_selftest_q(abort_st),
      .release_streams_q(rel_str), .power_suspend_q(pwr_susp), .fw_activate_block_q(fw_blk),
      .state_q(state), .unrestricted_exit_allowed_q(unres), .caps_q(caps));

   erase_engine_model i_erase_engine_model (.clk(clk), .rst_b(rst_b), .launch(launch),
      .fail_sel(eng_fail_sel), .delay(eng_delay), .done(eng_done), .fail(eng_fail));

   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic send(input logic san, input logic alw, input logic [31:0] w10, w11);
      @(posedge clk);
      #2;
      cmd = {1'b1, san, alw, w10, w11};
      // One cycle only, so conditions set after the call never touch this command
      @(posedge clk);
      #2;
      cmd.valid = 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         #2;
         cmd.valid = 1'b0;
      end
   endtask

   // Reference model: answers one cycle after each command, state from registered view
   always @(posedge clk) begin
      logic [2:0] act;
      logic       sup;
      if (!rst_b) begin
         e_valid = 1'b0; e_launch = 1'b0; e_fwd = 1'b0; e_chkfwd = 1'b0; e_chkst = 1'b0;
         m_state = sanitize_pkg::SAN_IDLE; m_unres = 1'b0; e_status = sanitize_pkg::ST_SUCCESS;
      end else begin
         check(cpl.valid, e_valid);
         if (e_chkst) check(cpl.status, e_status);
         if (e_chkfwd) check(cpl.forward, e_fwd);
         check({launch, clr_ev, log_up, abort_st, rel_str}, {5{e_launch}});
         check(state, m_state);
         check({pwr_susp, fw_blk}, {2{m_state == sanitize_pkg::SAN_BUSY}});
         check(unres, m_unres);
         e_valid = cmd.valid; e_launch = 1'b0; e_chkfwd = 1'b0; e_chkst = cmd.valid;
         e_status = sanitize_pkg::ST_SUCCESS;
         act = cmd.cdw10[2:0];
         sup = (act == sanitize_pkg::ACT_BLOCK_ERASE && TYPES[0]) ||
               (act == sanitize_pkg::ACT_CRYPTO_ERASE && TYPES[1]) ||
               (act == sanitize_pkg::ACT_OVERWRITE && TYPES[2]);
         if (m_state == sanitize_pkg::SAN_BUSY && (eng_done || eng_fail)) begin
            if (cmd.valid && !cmd.is_sanitize) begin
               e_chkfwd = 1'b1; e_fwd = cmd.allowed; e_chkst = !cmd.allowed;
               e_status = sanitize_pkg::ST_IN_PROGRESS;
            end
            if (cmd.valid && cmd.is_sanitize) e_status = pmr ? sanitize_pkg::ST_PMR_PROHIBITED :
               controller_side_buffer ? sanitize_pkg::ST_CMB_UNSUPPORTED : fwp ? (fws == sanitize_pkg::FWC_CONV_RESET ?
               sanitize_pkg::ST_FW_CONV_RESET : fws == sanitize_pkg::FWC_SUBSYS_RESET ?
               sanitize_pkg::ST_FW_SUBSYS_RESET : sanitize_pkg::ST_FW_CTRL_RESET) :
               sanitize_pkg::ST_IN_PROGRESS;
            m_state = eng_fail ? sanitize_pkg::SAN_FAILED : sanitize_pkg::SAN_IDLE;
         end else if (cmd.valid && !cmd.is_sanitize) begin
            e_chkfwd = 1'b1; e_fwd = cmd.allowed || m_state == sanitize_pkg::SAN_IDLE;
            e_chkst = !e_fwd;
            e_status = (m_state == sanitize_pkg::SAN_BUSY) ? sanitize_pkg::ST_IN_PROGRESS :
                       sanitize_pkg::ST_FAILED;
         end else if (cmd.valid) begin
            if (pmr) e_status = sanitize_pkg::ST_PMR_PROHIBITED;
            else if (controller_side_buffer) e_status = sanitize_pkg::ST_CMB_UNSUPPORTED;
            else if (fwp) e_status = (fws == sanitize_pkg::FWC_CONV_RESET) ?
               sanitize_pkg::ST_FW_CONV_RESET : (fws == sanitize_pkg::FWC_SUBSYS_RESET) ?
               sanitize_pkg::ST_FW_SUBSYS_RESET : sanitize_pkg::ST_FW_CTRL_RESET;
            else if (m_state == sanitize_pkg::SAN_BUSY) e_status = sanitize_pkg::ST_IN_PROGRESS;
            else if (act != sanitize_pkg::ACT_EXIT_FAILURE && !sup)
               e_status = sanitize_pkg::ST_INVALID_FIELD;
            else if (act == sanitize_pkg::ACT_EXIT_FAILURE) begin
               if (m_state == sanitize_pkg::SAN_FAILED && !m_unres) e_status = sanitize_pkg::ST_FAILED;
               else m_state = sanitize_pkg::SAN_IDLE;
            end else if (m_state == sanitize_pkg::SAN_FAILED && !m_unres && cmd.cdw10[3])
               e_status = sanitize_pkg::ST_FAILED;
            else begin
               e_launch = 1'b1; m_state = sanitize_pkg::SAN_BUSY; m_unres = cmd.cdw10[3];
            end
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      #2;
      rst_b = 1'b1;
      idle(1);
      check(caps, {TYPES, 1'b1, 1'b0});
      send(1'b1, 1'b0, 32'h1, 32'h0);
      send(1'b1, 1'b0, 32'h4, 32'h0);
      for (int k = 0; k < 4; k++) begin
         fwp = 1'b1;
         fws = sanitize_pkg::fw_commit_type'(k);
         send(1'b1, 1'b0, 32'hA, 32'h0);
      end
      fwp = 1'b0; pmr = 1'b1;
      send(1'b1, 1'b0, 32'hA, 32'h0);
      pmr = 1'b0; controller_side_buffer = 1'b1;
      send(1'b1, 1'b0, 32'hA, 32'h0);
      controller_side_buffer = 1'b0; eng_fail_sel = 1'b1;
      send(1'b1, 1'b0, 32'h2F3, 32'hC0DE1234);
      send(1'b1, 1'b0, 32'h2, 32'h0);
      send(1'b0, 1'b0, 32'h0, 32'h0);
      check({info.action, info.unrestricted, info.no_dealloc, info.invert, info.passes,
             info.pattern}, {3'h3, 1'b0, 1'b1, 1'b0, 4'hF, 32'hC0DE1234});
      idle(10);
      send(1'b1, 1'b0, 32'h1, 32'h0);
      send(1'b1, 1'b0, 32'hA, 32'h0);
      send(1'b0, 1'b0, 32'h0, 32'h0);
      send(1'b0, 1'b1, 32'h0, 32'h0);
      eng_fail_sel = 1'b0;
      send(1'b1, 1'b0, 32'h2, 32'h0);
      idle(10);
      eng_fail_sel = 1'b1;
      send(1'b1, 1'b0, 32'hA, 32'h0);
      idle(10);
      send(1'b1, 1'b0, 32'h1, 32'h0);
      eng_fail_sel = 1'b0;
      send(1'b1, 1'b0, 32'h3, 32'h0);
      idle(10);
      repeat (600) begin
         lfsr = next_rand(lfsr);
         eng_delay = lfsr[7:4];
         eng_fail_sel = lfsr[8];
         pmr = (lfsr[14:11] == 4'h0);
         controller_side_buffer = (lfsr[18:15] == 4'h0);
         fwp = (lfsr[22:19] == 4'h0);
         fws = sanitize_pkg::fw_commit_type'(lfsr[24:23]);
         if (lfsr[25]) send(lfsr[26], lfsr[27], {22'h0, lfsr[9], 5'h0, lfsr[3:0]}, lfsr);
         else idle(1);
      end
      idle(20);
      report_and_stop();
   end
endmodule // media_sanitize_command_handler_tb
